// File: design/pdr_pkg.sv
// Purpose: Shared constants and carriers for the detail-status and 10M operations registers
// Assumes: Register addresses are the 5-bit management register numbers
// Notes:   Every offset and field position is named once here, and each reset value except those of the event flags, tmux_out and rvalid
package pdr_pkg;

  // Register numbers on the management port
  localparam logic [4:0] ADDR_QPOLL     = 5'h11;
  localparam logic [4:0] ADDR_TBT_OPS   = 5'h12;
  localparam logic [4:0] ADDR_VENDOR_LO = 5'h19;
  localparam logic [4:0] ADDR_VENDOR_HI = 5'h1f;

  // Quick-poll detail status field positions
  localparam int QP_AN_LSB        = 11;
  localparam int QP_FALSE_CARRIER = 8;
  localparam int QP_HALT          = 6;
  localparam int QP_PREMATURE     = 5;
  localparam int QP_REMOTE_FAULT  = 1;

  // tenbase_t_operations field positions
  localparam int OPS_BUS_MODE_LSB = 12;
  localparam int OPS_RX_FLOAT     = 10;
  localparam int OPS_VENDOR_GATE  = 9;
  localparam int OPS_TEST_MUX     = 8;

  // Data-bus mode encodings; 2'h2 and 2'h3 are unsupported
  localparam logic [1:0] BUS_MODE_MII = 2'h0;
  localparam logic [1:0] BUS_MODE_SI  = 2'h1;

  // Reset values
  localparam logic [2:0]  RST_AN_PROG     = 3'h0;
  localparam logic [1:0]  RST_BUS_MODE    = 2'h0;
  localparam logic        RST_RX_FLOAT    = 1'h0;
  localparam logic        RST_VENDOR_GATE = 1'h0;
  localparam logic        RST_TEST_MUX    = 1'h0;
  localparam logic [15:0] RST_RDATA       = 16'h0000;

  // Receive-side events that latch high
  typedef struct packed {
    logic false_carrier;
    logic halt_symbol;
    logic premature_end;
    logic remote_fault;
  } pdr_events_s;

  // Strap levels, caught when the strap sample strobe fires
  typedef struct packed {
    logic rx_tri;
    logic serial_if;
    logic rx_float;
    logic vendor_gate;
  } pdr_strap_s;

  // Whole register state of the block
  typedef struct packed {
    logic [2:0]  an_prog;
    pdr_events_s ev;
    logic [1:0]  bus_mode;
    logic        rx_float;
    logic        vendor_gate;
    logic        test_sel;
    logic        tmux_out;
    logic [15:0] rdata;
    logic        rvalid;
  } pdr_state_s;

endpackage

// File: design/pdr_regs.sv
// Purpose: Quick-poll detail status bits 13 to 1 and tenbase_t_operations upper half
// Assumes: Management frame decoding happens upstream and arrives as read/write strobes
// Notes:   Contract
// Contract
// - Auto-negotiation progress bit 0 reads at 17.11, read-only, reset 0.
// - Progress bits 2 and 1 read at 17.13 and 17.12, read-only, reset 0.
// - False carrier sets 17.8, held high until read; otherwise 0.
// - Halt symbol on receive sets 17.6, latching high, reset 0.
// - Premature end with two idles sets 17.5, latching high.
// - Remote fault sets 17.1, latching high, read-only, reset 0.
// - 18.13 is read-only, loaded from receive tri-state strap at sampling.
// - 18.12 loaded from serial strap; field 00 MII, 01 serial, 1x unsupported.
// - 18.10 high floats MII receive outputs; low drives them; strap reset.
// - 18.9 low permits vendor registers 25 to 31; high blocks them.
// - 18.8 read-write, reset 0, picks test mux a over test mux b.
`timescale 1ns/1ps

module pdr_regs (
  input  wire logic               core_clk_i,
  input  wire logic               resetn_i,
  input  wire logic               mgmt_rd_i,
  input  wire logic               mgmt_wr_i,
  input  wire logic [4:0]         mgmt_addr_i,
  input  wire logic [15:0]        mgmt_wdata_i,
  output logic      [15:0]        mgmt_rdata_o,
  output logic                    mgmt_rvalid_o,
  output logic                    vendor_access_ok_o,
  input  wire logic [2:0]         an_progress_i,
  input  wire pdr_pkg::pdr_events_s events_i,
  input  wire logic               strap_sample_i,
  input  wire pdr_pkg::pdr_strap_s strap_i,
  output logic                    mii_rx_oe_o,
  output logic                    test_mux_select_o,
  input  wire logic               test_mux_a_i,
  input  wire logic               test_mux_b_i,
  output logic                    test_mux_o
);

  logic [1:0]          rst_sync;
  logic                rst_n;
  pdr_pkg::pdr_state_s q;
  pdr_pkg::pdr_state_s next_q;
  logic                rd_qp;
  logic                wr_ops;

  // True for the vendor-reserved register range
  function automatic logic is_vendor(input logic [4:0] a);
    is_vendor = (a >= pdr_pkg::ADDR_VENDOR_LO) && (a <= pdr_pkg::ADDR_VENDOR_HI);
  endfunction

  // Latch-high update; a new event beats the clear-on-read in the same cycle
  function automatic logic latch_hi(input logic cur, input logic ev, input logic clr);
    latch_hi = ev | (cur & ~clr);
  endfunction

  // Reset release through two flops so the release is clean on our clock
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  assign rd_qp  = mgmt_rd_i && (mgmt_addr_i == pdr_pkg::ADDR_QPOLL);
  assign wr_ops = mgmt_wr_i && (mgmt_addr_i == pdr_pkg::ADDR_TBT_OPS);

  // Next-state logic for the whole register set
  always_comb
  begin
    next_q = q;
    next_q.an_prog = an_progress_i;
    next_q.ev.false_carrier = latch_hi(q.ev.false_carrier, events_i.false_carrier, rd_qp);
    next_q.ev.halt_symbol   = latch_hi(q.ev.halt_symbol, events_i.halt_symbol, rd_qp);
    next_q.ev.premature_end = latch_hi(q.ev.premature_end, events_i.premature_end, rd_qp);
    next_q.ev.remote_fault  = latch_hi(q.ev.remote_fault, events_i.remote_fault, rd_qp);
    // Writable control bits; bus mode bits ignore writes
    if (wr_ops)
    begin
      next_q.rx_float    = mgmt_wdata_i[pdr_pkg::OPS_RX_FLOAT];
      next_q.vendor_gate = mgmt_wdata_i[pdr_pkg::OPS_VENDOR_GATE];
      next_q.test_sel    = mgmt_wdata_i[pdr_pkg::OPS_TEST_MUX];
    end
    // Strap sampling wins over a write in the same cycle, as it models power-up
    if (strap_sample_i)
    begin
      next_q.bus_mode    = {strap_i.rx_tri, strap_i.serial_if};
      next_q.rx_float    = strap_i.rx_float;
      next_q.vendor_gate = strap_i.vendor_gate;
    end
    next_q.tmux_out = q.test_sel ? test_mux_a_i : test_mux_b_i;
    // Read data: present value of the register, reserved bits read zero
    next_q.rvalid = mgmt_rd_i;
    next_q.rdata  = pdr_pkg::RST_RDATA;
    if (mgmt_rd_i)
    begin
      case (mgmt_addr_i)
        pdr_pkg::ADDR_QPOLL:
        begin
          next_q.rdata[pdr_pkg::QP_AN_LSB +: 3]        = q.an_prog;
          next_q.rdata[pdr_pkg::QP_FALSE_CARRIER]      = q.ev.false_carrier;
          next_q.rdata[pdr_pkg::QP_HALT]               = q.ev.halt_symbol;
          next_q.rdata[pdr_pkg::QP_PREMATURE]          = q.ev.premature_end;
          next_q.rdata[pdr_pkg::QP_REMOTE_FAULT]       = q.ev.remote_fault;
        end
        pdr_pkg::ADDR_TBT_OPS:
        begin
          next_q.rdata[pdr_pkg::OPS_BUS_MODE_LSB +: 2] = q.bus_mode;
          next_q.rdata[pdr_pkg::OPS_RX_FLOAT]          = q.rx_float;
          next_q.rdata[pdr_pkg::OPS_VENDOR_GATE]       = q.vendor_gate;
          next_q.rdata[pdr_pkg::OPS_TEST_MUX]          = q.test_sel;
        end
        default:
          next_q.rdata = pdr_pkg::RST_RDATA; // Unmapped or vendor space reads zero here
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.an_prog     <= pdr_pkg::RST_AN_PROG;
      q.ev          <= '0;
      q.bus_mode    <= pdr_pkg::RST_BUS_MODE;
      q.rx_float    <= pdr_pkg::RST_RX_FLOAT;
      q.vendor_gate <= pdr_pkg::RST_VENDOR_GATE;
      q.test_sel    <= pdr_pkg::RST_TEST_MUX;
      q.tmux_out    <= 1'b0;
      q.rdata       <= pdr_pkg::RST_RDATA;
      q.rvalid      <= 1'b0;
    end
    else
      q <= next_q;
  end

  // Outputs; vendor grant is combinational so the upstream decoder can act this cycle
  assign mgmt_rdata_o       = q.rdata;
  assign mgmt_rvalid_o      = q.rvalid;
  assign mii_rx_oe_o        = ~q.rx_float;
  assign test_mux_select_o  = q.test_sel;
  assign test_mux_o         = q.tmux_out;
  assign vendor_access_ok_o = (mgmt_rd_i | mgmt_wr_i) & is_vendor(mgmt_addr_i)
                              & ~q.vendor_gate;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  property p_an_bit0;
    mgmt_rd_i && mgmt_addr_i == pdr_pkg::ADDR_QPOLL |=>
      mgmt_rdata_o[pdr_pkg::QP_AN_LSB] == $past(an_progress_i[0], 2);
  endproperty
  a_an_bit0: assert property (p_an_bit0) else $error("progress bit 0 misreported");

  property p_an_hi;
    ##1 q.an_prog[2:1] == $past(an_progress_i[2:1]);
  endproperty
  a_an_hi: assert property (p_an_hi) else $error("progress bits 2:1 not tracked");

  // A quiet cycle after the event must not lose the latched flag
  property p_fc_hold;
    events_i.false_carrier ##1 !rd_qp |=> q.ev.false_carrier;
  endproperty
  a_fc_hold: assert property (p_fc_hold) else $error("false carrier not held");

  property p_halt;
    events_i.halt_symbol |=> q.ev.halt_symbol;
  endproperty
  a_halt: assert property (p_halt) else $error("halt symbol not latched");

  property p_premature;
    events_i.premature_end |=> q.ev.premature_end;
  endproperty
  a_premature: assert property (p_premature) else $error("premature end not latched");

  property p_rf;
    events_i.remote_fault ##1 (rd_qp && !events_i.remote_fault) |=>
      mgmt_rdata_o[pdr_pkg::QP_REMOTE_FAULT] && !q.ev.remote_fault;
  endproperty
  a_rf: assert property (p_rf) else $error("remote fault read or clear wrong");

  property p_strap_tri;
    strap_sample_i |=> q.bus_mode[1] == $past(strap_i.rx_tri);
  endproperty
  a_strap_tri: assert property (p_strap_tri) else $error("rx tri strap not loaded");

  property p_strap_si;
    strap_sample_i |=> q.bus_mode[0] == $past(strap_i.serial_if);
  endproperty
  a_strap_si: assert property (p_strap_si) else $error("serial strap not loaded");

  // Mode bits are read-only: only the strap strobe may move them, never a write
  property p_mode_ro;
    !strap_sample_i |=> $stable(q.bus_mode);
  endproperty
  a_mode_ro: assert property (p_mode_ro) else $error("bus mode changed without strap");

  property p_float;
    wr_ops && !strap_sample_i |=> mii_rx_oe_o == !$past(mgmt_wdata_i[pdr_pkg::OPS_RX_FLOAT]);
  endproperty
  a_float: assert property (p_float) else $error("rx output enable wrong");

  property p_vendor;
    q.vendor_gate |-> !vendor_access_ok_o;
  endproperty
  a_vendor: assert property (p_vendor) else $error("vendor access not blocked");

  property p_tmux;
    q.test_sel && $stable(q.test_sel) |=> test_mux_o == $past(test_mux_a_i);
  endproperty
  a_tmux: assert property (p_tmux) else $error("test mux a not selected");

  property p_clear;
    rd_qp && !events_i.halt_symbol |=> !q.ev.halt_symbol;
  endproperty
  a_clear: assert property (p_clear) else $error("latched bit not cleared on read");

  property p_cov_flag_read;
    q.ev.false_carrier && rd_qp;
  endproperty
  c_flag_read: cover property (p_cov_flag_read);

  property p_cov_si;
    strap_sample_i && strap_i.serial_if && !strap_i.rx_tri;
  endproperty
  c_si: cover property (p_cov_si);

  property p_cov_vendor_block;
    mgmt_rd_i && is_vendor(mgmt_addr_i) && q.vendor_gate;
  endproperty
  c_vendor_block: cover property (p_cov_vendor_block);

endmodule

// File: dv/pdr_sta_model.sv
// Purpose: Management controller model driving the register port strobes
// Assumes: One request per rising edge, all lines changed just after the edge
// Notes:   Released address and data lines show inverted values, never stale ones
`timescale 1ns/1ps

module pdr_sta_model (
  input  wire logic        clk_i,
  output logic             rd_o,
  output logic             wr_o,
  output logic [4:0]       addr_o,
  output logic [15:0]      wdata_o
);
  // Quiet port from time zero
  initial
  begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 16'h0000;
  end

  // One-edge request; the caller follows with idle or another request
  task automatic req(input logic rd, input logic wr, input logic [4:0] a,
                     input logic [15:0] d);
    @(posedge clk_i);
    rd_o    <= rd;
    wr_o    <= wr;
    addr_o  <= a;
    wdata_o <= d;
  endtask

  // Inverting released lines keeps a stale address from passing unseen
  task automatic idle();
    @(posedge clk_i);
    rd_o    <= 1'b0;
    wr_o    <= 1'b0;
    addr_o  <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask
endmodule

// File: dv/pdr_regs_bench.sv
// Purpose: Self-checking bench for the detail-status and operations registers
// Assumes: Read answers come one cycle after the strobe, in request order
// Notes:   Expected read words queue up in the driver; a monitor pairs them
`timescale 1ns/1ps

module pdr_regs_bench;
  logic                 core_clk_i;
  logic                 resetn_i;
  logic                 rd, wr, rvalid, vend_ok, rx_oe, tsel, ta, tb, tmux, strobe;
  logic [4:0]           addr;
  logic [15:0]          wdata, rdata, w;
  logic [2:0]           an_prog;
  logic [3:0]           s;
  pdr_pkg::pdr_events_s ev;
  pdr_pkg::pdr_strap_s  strap;
  logic [15:0]          exp_q[$];
  int                   error_cnt = 0;
  int                   n_compared = 0;

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  pdr_regs uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .mgmt_rd_i(rd),
    .mgmt_wr_i(wr), .mgmt_addr_i(addr), .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata),
    .mgmt_rvalid_o(rvalid), .vendor_access_ok_o(vend_ok), .an_progress_i(an_prog),
    .events_i(ev), .strap_sample_i(strobe), .strap_i(strap), .mii_rx_oe_o(rx_oe),
    .test_mux_select_o(tsel), .test_mux_a_i(ta), .test_mux_b_i(tb), .test_mux_o(tmux));

  pdr_sta_model sta (.clk_i(core_clk_i), .rd_o(rd), .wr_o(wr), .addr_o(addr),
    .wdata_o(wdata));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Status word as it should read for the given latched events
  function automatic logic [15:0] qp(input logic [3:0] e);
    return {2'b00, an_prog, 2'b00, e[3], 1'b0, e[2], e[1], 3'b000, e[0], 1'b0};
  endfunction

  task automatic rd_exp(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    sta.req(1'b1, 1'b0, a, 16'h0000);
  endtask

  // Every answer pairs with the oldest outstanding read; extra answers fail
  always @(posedge core_clk_i)
    if (rvalid === 1'b1)
      chk(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : ~rdata);

  initial
  begin
    #20000;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'hc8b1c8cd));
    resetn_i = 1'b0;
    an_prog = 3'h0;
    ev = '0;
    strap = '0;
    strobe = 1'b0;
    ta = 1'b0;
    tb = 1'b0;
    repeat (3) @(posedge core_clk_i);
    chk({14'h0, rx_oe, tsel}, 16'h0002);
    resetn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rd_exp(pdr_pkg::ADDR_QPOLL, 16'h0000);
    rd_exp(pdr_pkg::ADDR_TBT_OPS, 16'h0000);
    rd_exp(5'h05, 16'h0000);
    an_prog <= 3'($urandom);
    sta.idle();
    rd_exp(pdr_pkg::ADDR_QPOLL, qp(4'h0));
    // Each event: set, held through a read while present, cleared by the next read
    for (int i = 0; i < 4; i++)
    begin
      ev <= pdr_pkg::pdr_events_s'(4'h1 << i);
      sta.idle();
      rd_exp(pdr_pkg::ADDR_QPOLL, qp(4'h1 << i));
      rd_exp(pdr_pkg::ADDR_QPOLL, qp(4'h1 << i));
      ev <= '0;
      rd_exp(pdr_pkg::ADDR_QPOLL, qp(4'h0));
    end
    // Writes, vendor window edges and the test mux path
    for (int i = 0; i < 4; i++)
    begin
      w = 16'($urandom);
      w[8] = i[0];
      w[9] = ~i[1];
      sta.req(1'b0, 1'b1, pdr_pkg::ADDR_QPOLL, 16'hffff);
      sta.req(1'b0, 1'b1, pdr_pkg::ADDR_TBT_OPS, w);
      ta <= 1'($urandom);
      tb <= 1'($urandom);
      rd_exp(pdr_pkg::ADDR_QPOLL, qp(4'h0));
      rd_exp(5'h18 + 5'(i * 2 + i / 3), 16'h0000);
      #1 chk({15'h0, vend_ok}, {15'h0, i > 1});
      sta.idle();
      #1 chk({13'h0, tmux, rx_oe, tsel}, {13'h0, w[8] ? ta : tb, ~w[10], w[8]});
      rd_exp(pdr_pkg::ADDR_TBT_OPS, w & 16'h0700);
    end
    // Straps win over a same-cycle write and are not followed afterwards
    for (int i = 0; i < 4; i++)
    begin
      s = 4'($urandom);
      s[3:2] = 2'(i);
      w = 16'($urandom);
      sta.req(1'b0, 1'b1, pdr_pkg::ADDR_TBT_OPS, w);
      strap <= pdr_pkg::pdr_strap_s'(s);
      strobe <= 1'b1;
      sta.idle();
      strobe <= 1'b0;
      strap <= pdr_pkg::pdr_strap_s'(~s);
      rd_exp(pdr_pkg::ADDR_TBT_OPS, {2'b00, s[3:2], 1'b0, s[1:0], w[8], 8'h00});
      #1 chk({15'h0, rx_oe}, {15'h0, ~s[1]});
    end
    sta.idle();
    repeat (2) @(posedge core_clk_i);
    chk(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule
